//--- logic/nsp_controller.v
// nonvolatile memory front end: sections, protection, read stall, page operations
// assumes a memory array port that takes one byte per cycle and reports busy
//
// Overview of operation
// - runs only on the processor clock; requests clock in sleep while busy
// - debugger halt suspends command and buffer activity; run-time debug normal
// - flash operations always cover a full page
// - boot ends at 256*boot fuse, app code ends at 256*app fuse
// - app fuse zero: code runs to end; both zero: all boot
// - app fuse equal to boot fuse: no code section, data to end
// - boot writes code and data, code writes data, data writes nothing
// - code protect and boot lock bits stick until reset
// - boot writable only from an unlocked debug interface; boot lock also blocks boot reads and fetches
// - eeprom erase and write only touch marked bytes
// - user row is one extra eeprom page kept through chip erase
// - user row writable from debug interface even when locked
// - reads during write or erase get wait states until done
// - flash, eeprom and user row share one page buffer
// - low address bits pick buffer byte; value ands with old content
// - buffer all ones after reset, page op, clear command, wake
// - eeprom programming proceeds while processor executes from flash
// - processor halted during flash operations, runs during eeprom ones
`timescale 1ns/1ps
module nsp_controller #(
	parameter FAW = 14,
	parameter PAW = 6,
	parameter EAW = 8
) (
	input  wire           clk,
	input  wire           resetn,
	input  wire [7:0]     boot_section_end_fuse,
	input  wire [7:0]     app_code_section_end_fuse,
	input  wire           device_locked,
	input  wire           debug_halt,
	input  wire           sleep_active,
	input  wire           wake,
	input  wire [FAW-1:0] fetch_addr,
	input  wire           set_app_code_write_protect_bit,
	input  wire           set_boot_section_lock_bit,
	input  wire           bus_wr,
	input  wire           bus_rd,
	input  wire [1:0]     bus_target,
	input  wire [FAW-1:0] bus_addr,
	input  wire [7:0]     bus_wdata,
	input  wire           bus_from_debug,
	input  wire           cmd_valid,
	input  wire [2:0]     cmd_code,
	input  wire           array_busy,
	output reg            bus_wait,
	output reg            rd_blocked,
	output reg            fetch_blocked,
	output reg            wr_discarded,
	output reg            busy,
	output reg            cpu_halt,
	output reg            clk_request,
	output reg            app_code_write_protect_bit,
	output reg            boot_section_lock_bit,
	output reg [1:0]      exec_section,
	output reg            arr_wr,
	output reg            arr_erase,
	output reg [1:0]      arr_target,
	output reg [FAW-1:0]  arr_addr,
	output reg [7:0]      arr_wdata
);
`include "nsp_defs.vh"
	localparam ST_IDLE  = 3'h0;
	localparam ST_ERASE = 3'h1;
	localparam ST_WRITE = 3'h2;
	localparam ST_WAIT  = 3'h3;
	localparam ST_CLEAR = 3'h4;
	localparam [FAW-1:0] LAST_ADDR = {FAW{1'b1}};
	localparam [PAW-1:0] LAST_BYTE = {PAW{1'b1}};

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	reg rst_s1;
	reg rst_n;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// ----------------------------------------------------------------
	// section decode
	// ----------------------------------------------------------------
	// fuse value scaled to a byte address, saturated to one past the last address
	function [FAW:0] fuse_addr;
		input [7:0] f;
		reg   [FAW+8:0] wide;
		begin
			wide = {{(FAW+1){1'b0}}, f} << `NSP_BLOCK_SHIFT;
			fuse_addr = (wide > {8'h00, 1'b0, LAST_ADDR}) ?
				{1'b0, LAST_ADDR} + {{FAW{1'b0}}, 1'b1} : wide[FAW:0];
		end
	endfunction

	function [1:0] section_of;
		input [FAW-1:0] a;
		input [7:0]     be;
		input [7:0]     ae;
		reg   [FAW:0]   ax;
		begin
			ax = {1'b0, a};
			if (be == 8'h00 && ae == 8'h00)
				section_of = `NSP_SEC_BOOT;
			else if (ax < fuse_addr(be))
				section_of = `NSP_SEC_BOOT;
			else if (ae == 8'h00)
				section_of = `NSP_SEC_CODE;
			else if (ae <= be)
				section_of = `NSP_SEC_DATA; // also covers a misprogrammed fuse
			else if (ax < fuse_addr(ae))
				section_of = `NSP_SEC_CODE;
			else
				section_of = `NSP_SEC_DATA;
		end
	endfunction

	wire [1:0] fetch_sec = section_of(fetch_addr, boot_section_end_fuse,
		app_code_section_end_fuse);
	wire [1:0] dest_sec  = section_of(bus_addr, boot_section_end_fuse,
		app_code_section_end_fuse);

	// ----------------------------------------------------------------
	// state and page buffer
	// ----------------------------------------------------------------
	reg [2:0]     state;
	reg [2:0]     next_state;
	reg [PAW-1:0] idx;
	reg [3:0]     clr_cnt;
	reg [1:0]     op_target;
	reg [FAW-1:0] page_base;
	reg           do_write;
	reg           page_valid;
	wire          buf_clear;
	wire          buf_load;
	wire [7:0]    buf_data;
	wire          buf_mark;
	wire          buf_any;
	wire          idle = (state == ST_IDLE);
	wire          is_flash = (op_target == `NSP_TGT_FLASH); // user row runs as eeprom

	// write legality
	wire locked_dest = bus_target == `NSP_TGT_FLASH &&
		((dest_sec == `NSP_SEC_BOOT && boot_section_lock_bit) ||
		(dest_sec == `NSP_SEC_CODE && app_code_write_protect_bit));
	reg wr_ok;
	always @* begin
		wr_ok = 1'b0;
		if (bus_from_debug && bus_target == `NSP_TGT_USERROW)
			wr_ok = 1'b1; // locked device does not matter here
		else if (bus_from_debug)
			wr_ok = !device_locked && !locked_dest;
		else if (fetch_sec == `NSP_SEC_DATA)
			wr_ok = 1'b0;
		else if (bus_target != `NSP_TGT_FLASH)
			wr_ok = 1'b1;
		else if (dest_sec == `NSP_SEC_BOOT)
			wr_ok = 1'b0;
		else if (dest_sec == `NSP_SEC_CODE)
			wr_ok = (fetch_sec == `NSP_SEC_BOOT) && !app_code_write_protect_bit;
		else
			wr_ok = 1'b1;
	end

	wire suspend = debug_halt;
	assign buf_load = bus_wr && idle && wr_ok && !suspend;
	wire   finish   = (state == ST_WAIT && !array_busy) ||
		(state == ST_CLEAR && clr_cnt == 4'h0);
	assign buf_clear = finish || wake;

	nsp_page_buffer #(
		.AW (PAW)
	) u_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.clear     (buf_clear),
		.load      (buf_load),
		.load_addr (bus_addr[PAW-1:0]),
		.load_data (bus_wdata),
		.rd_addr   (idx),
		.rd_data   (buf_data),
		.rd_mark   (buf_mark),
		.any_mark  (buf_any)
	);

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	wire step_ok = !array_busy;
	wire last    = (idx == LAST_BYTE);
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (cmd_valid && !suspend) begin // key check lives in the core
				if (cmd_code == `NSP_CMD_CLEAR_BUF)
					next_state = ST_CLEAR;
				else if (page_valid && buf_any &&
					(cmd_code == `NSP_CMD_ERASE || cmd_code == `NSP_CMD_ERASE_WRITE))
					next_state = ST_ERASE;
				else if (page_valid && cmd_code == `NSP_CMD_WRITE)
					next_state = ST_WRITE;
			end
		end
		ST_ERASE: if (step_ok && last) next_state = do_write ? ST_WRITE : ST_WAIT;
		ST_WRITE: if (step_ok && last) next_state = ST_WAIT;
		ST_WAIT:  if (!array_busy) next_state = ST_IDLE;
		ST_CLEAR: if (clr_cnt == 4'h0) next_state = ST_IDLE;
		default:  next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			idx        <= {PAW{1'b0}};
			clr_cnt    <= 4'h0;
			op_target  <= `NSP_TGT_FLASH;
			page_base  <= {FAW{1'b0}};
			do_write   <= 1'b0;
			page_valid <= 1'b0;
			arr_wr     <= 1'b0;
			arr_erase  <= 1'b0;
			arr_target <= `NSP_TGT_FLASH;
			arr_addr   <= {FAW{1'b0}};
			arr_wdata  <= `NSP_BUF_ONES;
		end else begin
			state     <= next_state;
			arr_wr    <= 1'b0;
			arr_erase <= 1'b0;
			if (buf_load) begin
				op_target  <= bus_target; // last target owns the buffer
				page_base  <= {bus_addr[FAW-1:PAW], {PAW{1'b0}}};
				page_valid <= 1'b1;
			end
			if (buf_clear)
				page_valid <= 1'b0;
			if (state == ST_IDLE) begin
				idx      <= {PAW{1'b0}};
				do_write <= (cmd_code == `NSP_CMD_ERASE_WRITE);
				clr_cnt  <= `NSP_CLEAR_CYCLES - 4'h1;
			end
			if (state == ST_CLEAR && clr_cnt != 4'h0)
				clr_cnt <= clr_cnt - 4'h1;
			if ((state == ST_ERASE || state == ST_WRITE) && step_ok) begin
				// flash: every byte of the page eeprom: marked bytes only
				arr_erase  <= (state == ST_ERASE) && (is_flash || buf_mark);
				arr_wr     <= (state == ST_WRITE) && (is_flash || buf_mark);
				arr_target <= op_target;
				arr_addr   <= page_base | {{(FAW-PAW){1'b0}}, idx};
				arr_wdata  <= buf_data;
				idx        <= last ? {PAW{1'b0}} : idx + {{(PAW-1){1'b0}}, 1'b1};
			end
		end
	end

	// ----------------------------------------------------------------
	// lock bits and status
	// ----------------------------------------------------------------
	wire op_busy    = !idle && state != ST_CLEAR;
	wire boot_read  = bus_rd && bus_target == `NSP_TGT_FLASH && dest_sec == `NSP_SEC_BOOT;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			app_code_write_protect_bit <= 1'b0;
			boot_section_lock_bit      <= 1'b0;
			bus_wait      <= 1'b0;
			rd_blocked    <= 1'b0;
			fetch_blocked <= 1'b0;
			wr_discarded  <= 1'b0;
			busy          <= 1'b0;
			cpu_halt      <= 1'b0;
			clk_request   <= 1'b0;
			exec_section  <= `NSP_SEC_BOOT;
		end else begin
			if (set_app_code_write_protect_bit)
				app_code_write_protect_bit <= 1'b1;
			if (set_boot_section_lock_bit)
				boot_section_lock_bit <= 1'b1;
			bus_wait      <= bus_rd && (op_busy || array_busy);
			rd_blocked    <= boot_read && boot_section_lock_bit;
			fetch_blocked <= boot_section_lock_bit && fetch_sec == `NSP_SEC_BOOT;
			wr_discarded  <= bus_wr && !(idle && wr_ok && !suspend);
			busy          <= op_busy || array_busy;
			// flash ops and buffer clear halt the core, eeprom ops do not
			cpu_halt      <= (op_busy && is_flash) || (next_state == ST_CLEAR) ||
				(!idle && next_state != ST_IDLE && is_flash);
			clk_request   <= (op_busy || array_busy) && (sleep_active || 1'b1);
			exec_section  <= fetch_sec;
		end
	end

endmodule // nsp_controller

//--- logic/nsp_defs.vh
// constants for the nonvolatile memory section protect and page buffer front end
// assumes inclusion by bare name from the design files under logic/
`ifndef NSP_DEFS_VH
`define NSP_DEFS_VH

// section granularity: one fuse step is 256 bytes (shift by 8)
`define NSP_BLOCK_SHIFT     8
// memory command codes on the command port
`define NSP_CMD_NONE        3'h0
`define NSP_CMD_WRITE       3'h1
`define NSP_CMD_ERASE       3'h2
`define NSP_CMD_ERASE_WRITE 3'h3
`define NSP_CMD_CLEAR_BUF   3'h4
// target region of a page operation
`define NSP_TGT_FLASH       2'h0
`define NSP_TGT_EEPROM      2'h1
`define NSP_TGT_USERROW     2'h2
// executing section codes
`define NSP_SEC_BOOT        2'h0
`define NSP_SEC_CODE        2'h1
`define NSP_SEC_DATA        2'h2
// page buffer cleared state
`define NSP_BUF_ONES        8'hff
// clear-buffer command occupancy in cycles
`define NSP_CLEAR_CYCLES    4'h7

`endif

//--- logic/nsp_page_buffer.v
// shared page buffer: byte array with and-merge and per-byte written marks
// assumes clk and an already synchronised active low reset
`timescale 1ns/1ps
module nsp_page_buffer #(
	parameter AW = 6
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          clear,
	input  wire          load,
	input  wire [AW-1:0] load_addr,
	input  wire [7:0]    load_data,
	input  wire [AW-1:0] rd_addr,
	output wire [7:0]    rd_data,
	output wire          rd_mark,
	output wire          any_mark
);
`include "nsp_defs.vh"
	localparam DEPTH = 1 << AW;

	reg [7:0]       mem [0:DEPTH-1];
	reg [DEPTH-1:0] mark;
	integer         i;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= `NSP_BUF_ONES;
			mark <= {DEPTH{1'b0}};
		end else if (clear) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= `NSP_BUF_ONES;
			mark <= {DEPTH{1'b0}};
		end else if (load) begin
			mem[load_addr]  <= mem[load_addr] & load_data;
			mark[load_addr] <= 1'b1;
		end
	end

	assign rd_data  = mem[rd_addr];
	assign rd_mark  = mark[rd_addr];
	assign any_mark = |mark;
endmodule // nsp_page_buffer

//--- verif/nsp_controller_assertions.sv
// port checker for nsp_controller
// assumes binding onto nsp_controller with its clk and resetn
`timescale 1ns/1ps
module nsp_chk #(
	parameter FAW = 14
) (
	input wire           clk,
	input wire           resetn,
	input wire [7:0]     boot_section_end_fuse,
	input wire [7:0]     app_code_section_end_fuse,
	input wire           debug_halt,
	input wire           bus_wr,
	input wire           bus_rd,
	input wire [1:0]     bus_target,
	input wire [FAW-1:0] bus_addr,
	input wire           bus_from_debug,
	input wire           set_boot_section_lock_bit,
	input wire           busy,
	input wire           bus_wait,
	input wire           wr_discarded,
	input wire           cpu_halt,
	input wire           clk_request,
	input wire           app_code_write_protect_bit,
	input wire           boot_section_lock_bit,
	input wire           arr_wr,
	input wire [1:0]     arr_target
);
	// flash write target lies inside the boot section
	wire in_boot = (boot_section_end_fuse == 8'h00 && app_code_section_end_fuse == 8'h00) ||
		({{(24-FAW){1'b0}}, bus_addr} < {8'h00, boot_section_end_fuse, 8'h00});
	wire cpu_wr = bus_wr && !busy && !debug_halt && !bus_from_debug;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_rd_wait; bus_rd |=> bus_wait == busy; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read while busy got no wait");
	property p_clk_req; busy |-> clk_request; endproperty
	a_clk_req: assert property (p_clk_req) else $error("clock not requested while busy");
	property p_wp_stick; app_code_write_protect_bit |=> app_code_write_protect_bit; endproperty
	a_wp_stick: assert property (p_wp_stick) else $error("code protect bit dropped");
	property p_lock_stick; boot_section_lock_bit |=> $stable(boot_section_lock_bit); endproperty
	a_lock_stick: assert property (p_lock_stick) else $error("boot lock bit dropped");
	property p_lock_set; set_boot_section_lock_bit |-> ##[1:2] boot_section_lock_bit; endproperty
	a_lock_set: assert property (p_lock_set) else $error("boot lock bit not set");
	property p_busy_disc; bus_wr |=> !busy || wr_discarded; endproperty
	a_busy_disc: assert property (p_busy_disc) else $error("write while busy kept");
	property p_boot_wr; cpu_wr && bus_target == 2'h0 && in_boot |=> wr_discarded; endproperty
	a_boot_wr: assert property (p_boot_wr) else $error("boot section write kept");
	property p_fl_halt; arr_wr && arr_target == 2'h0 |-> cpu_halt; endproperty
	a_fl_halt: assert property (p_fl_halt) else $error("cpu runs during flash write");
	property p_ee_run; arr_wr && arr_target == 2'h1 |-> !cpu_halt; endproperty
	a_ee_run: assert property (p_ee_run) else $error("cpu halted during eeprom write");
endmodule // nsp_chk

bind nsp_controller nsp_chk #(.FAW(FAW)) u_chk (.clk, .resetn, .boot_section_end_fuse,
	.app_code_section_end_fuse, .debug_halt, .bus_wr, .bus_rd, .bus_target, .bus_addr,
	.bus_from_debug, .set_boot_section_lock_bit, .busy, .bus_wait, .wr_discarded, .cpu_halt,
	.clk_request, .app_code_write_protect_bit, .boot_section_lock_bit, .arr_wr, .arr_target);

//--- verif/nsp_array_model.sv
// memory array model: busy from each byte or erase pulse through LAT cycles after it
// assumes the controller waits for array_busy low between pulses
`timescale 1ns/1ps
module nsp_array_model #(
	parameter LAT = 6
) (
	input wire  clk,
	input wire  resetn,
	input wire  arr_wr,
	input wire  arr_erase,
	output wire array_busy
);
	reg [7:0] cnt;
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			cnt <= 8'h00;
		else if (arr_wr || arr_erase)
			cnt <= 8'(LAT);
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
	assign array_busy = (cnt != 8'h00) || arr_wr || arr_erase;
endmodule // nsp_array_model

//--- verif/tb.sv
// self-checking bench for nsp_controller with an array model
// assumes a 100 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
`include "nsp_defs.vh"
module tb;
	reg clk, resetn, device_locked, debug_halt, sleep_active, wake, bus_wr, bus_rd, cmd_valid;
	reg set_app_code_write_protect_bit, set_boot_section_lock_bit, bus_from_debug;
	reg [7:0] boot_section_end_fuse, app_code_section_end_fuse, bus_wdata;
	reg [13:0] fetch_addr, bus_addr;
	reg [1:0] bus_target;
	reg [2:0] cmd_code;
	wire array_busy, bus_wait, rd_blocked, fetch_blocked, wr_discarded, busy, cpu_halt;
	wire clk_request, app_code_write_protect_bit, boot_section_lock_bit, arr_wr, arr_erase;
	wire [1:0] exec_section, arr_target;
	wire [13:0] arr_addr;
	wire [7:0] arr_wdata;
	integer err_total, checks_done, n_wr, n_er, i;
	reg halt_seen;
	reg [13:0] last_addr;
	reg [1:0] last_tgt;
	reg [7:0] mem [0:63];
	nsp_controller uut (.clk, .resetn, .boot_section_end_fuse, .app_code_section_end_fuse,
		.device_locked, .debug_halt, .sleep_active, .wake, .fetch_addr,
		.set_app_code_write_protect_bit, .set_boot_section_lock_bit, .bus_wr, .bus_rd,
		.bus_target, .bus_addr, .bus_wdata, .bus_from_debug, .cmd_valid, .cmd_code,
		.array_busy, .bus_wait, .rd_blocked, .fetch_blocked, .wr_discarded, .busy, .cpu_halt,
		.clk_request, .app_code_write_protect_bit, .boot_section_lock_bit, .exec_section,
		.arr_wr, .arr_erase, .arr_target, .arr_addr, .arr_wdata);
	nsp_array_model #(.LAT(6)) u_arr (.clk, .resetn, .arr_wr, .arr_erase, .array_busy);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (arr_wr) begin
			n_wr = n_wr + 1;
			mem[arr_addr[5:0]] = arr_wdata;
			last_addr = arr_addr;
			last_tgt = arr_target;
		end
		if (arr_erase)
			n_er = n_er + 1;
		if (busy && cpu_halt)
			halt_seen = 1'b1;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task cmp(input [15:0] got, input [15:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task wr(input [1:0] t, input [13:0] a, input [7:0] d, input disc);
		begin
			@(negedge clk);
			{bus_wr, bus_target, bus_addr, bus_wdata} = {1'b1, t, a, d};
			@(negedge clk);
			bus_wr = 1'b0;
			cmp(wr_discarded, disc);
		end
	endtask
	task rd(input [13:0] a);
		begin
			@(negedge clk);
			{bus_rd, bus_target, bus_addr} = {1'b1, `NSP_TGT_FLASH, a};
			@(negedge clk);
			bus_rd = 1'b0;
		end
	endtask
	task exec(input [13:0] f);
		begin
			fetch_addr = f;
			cyc(3);
		end
	endtask
	task sec(input [7:0] b, input [7:0] a, input [13:0] f, input [1:0] e);
		begin
			boot_section_end_fuse = b;
			app_code_section_end_fuse = a;
			exec(f);
			cmp(exec_section, e);
		end
	endtask
	task run_cmd(input [2:0] c);
		begin
			{n_wr, n_er, halt_seen} = 0;
			@(negedge clk);
			{cmd_valid, cmd_code} = {1'b1, c};
			@(negedge clk);
			cmd_valid = 1'b0;
			for (i = 0; i < 20 && busy !== 1'b1; i = i + 1) @(negedge clk);
			if (c != `NSP_CMD_CLEAR_BUF) begin
				rd(14'h0900);
				cmp(bus_wait, 1'b1);
				cmp(clk_request, 1'b1);
				wr(`NSP_TGT_EEPROM, 14'h0009, 8'h00, 1'b1);
			end
			for (i = 0; i < 3000 && busy !== 1'b0; i = i + 1) @(negedge clk);
			cmp(busy, 1'b0);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_sections;
		begin
			sec(8'h00, 8'h00, 14'h3000, `NSP_SEC_BOOT);
			sec(8'h04, 8'h00, 14'h3000, `NSP_SEC_CODE);
			sec(8'h04, 8'h04, 14'h3000, `NSP_SEC_DATA);
			sec(8'h04, 8'h08, 14'h03ff, `NSP_SEC_BOOT);
			sec(8'h04, 8'h08, 14'h0400, `NSP_SEC_CODE);
			sec(8'h04, 8'h08, 14'h0800, `NSP_SEC_DATA);
			$display("sections done");
		end
	endtask
	task t_protect;
		begin
			exec(14'h0900);
			wr(`NSP_TGT_EEPROM, 14'h0003, 8'h00, 1'b1);
			exec(14'h0500);
			wr(`NSP_TGT_FLASH, 14'h0600, 8'h00, 1'b1);
			wr(`NSP_TGT_FLASH, 14'h0900, 8'h00, 1'b0);
			exec(14'h0100);
			wr(`NSP_TGT_FLASH, 14'h0600, 8'h00, 1'b0);
			wr(`NSP_TGT_FLASH, 14'h0100, 8'h00, 1'b1);
			run_cmd(`NSP_CMD_CLEAR_BUF);
			$display("protect done");
		end
	endtask
	task t_pages;
		begin
			wr(`NSP_TGT_EEPROM, 14'h0003, 8'hf0, 1'b0);
			wr(`NSP_TGT_EEPROM, 14'h0003, 8'h3c, 1'b0);
			wr(`NSP_TGT_EEPROM, 14'h0005, 8'ha5, 1'b0);
			run_cmd(`NSP_CMD_WRITE);
			cmp(n_wr, 16'h0002);
			cmp(mem[3], 8'h30);
			cmp(mem[5], 8'ha5);
			cmp({last_tgt, last_addr}, {`NSP_TGT_EEPROM, 14'h0005});
			cmp(halt_seen, 1'b0);
			wr(`NSP_TGT_EEPROM, 14'h0003, 8'h00, 1'b0);
			run_cmd(`NSP_CMD_ERASE);
			cmp(n_er != 0 && n_wr == 0, 1'b1);
			wr(`NSP_TGT_FLASH, 14'h0905, 8'h11, 1'b0);
			sleep_active = 1'b1;
			run_cmd(`NSP_CMD_ERASE_WRITE);
			sleep_active = 1'b0;
			cmp(n_wr, 16'h0040);
			cmp({last_tgt, last_addr}, {`NSP_TGT_FLASH, 14'h093f});
			cmp({mem[5], mem[6]}, 16'h11ff);
			cmp(halt_seen, 1'b1);
			$display("pages done");
		end
	endtask
	task t_clear;
		integer k;
		for (k = 0; k < 2; k = k + 1) begin
			wr(`NSP_TGT_EEPROM, 14'h0007, 8'h12, 1'b0);
			if (k == 0)
				run_cmd(`NSP_CMD_CLEAR_BUF);
			else begin
				wake = 1'b1;
				cyc(1);
				wake = 1'b0;
				cyc(2);
			end
			wr(`NSP_TGT_EEPROM, 14'h0007, 8'hfe, 1'b0);
			run_cmd(`NSP_CMD_WRITE);
			cmp(mem[7], 8'hfe);
			cmp(n_wr, 16'h0001);
		end
		$display("clear done");
	endtask
	task t_lock;
		begin
			set_boot_section_lock_bit = 1'b1;
			cyc(1);
			set_boot_section_lock_bit = 1'b0;
			cyc(6);
			cmp(boot_section_lock_bit, 1'b1);
			rd(14'h0100);
			cmp(rd_blocked, 1'b1);
			cmp(fetch_blocked, 1'b1);
			set_app_code_write_protect_bit = 1'b1;
			cyc(1);
			set_app_code_write_protect_bit = 1'b0;
			cyc(2);
			cmp(app_code_write_protect_bit, 1'b1);
			wr(`NSP_TGT_FLASH, 14'h0600, 8'h00, 1'b1);
			debug_halt = 1'b1;
			wr(`NSP_TGT_EEPROM, 14'h0003, 8'h00, 1'b1);
			debug_halt = 1'b0;
			{device_locked, bus_from_debug} = 2'b11;
			wr(`NSP_TGT_USERROW, 14'h0003, 8'h00, 1'b0);
			wr(`NSP_TGT_EEPROM, 14'h0003, 8'h00, 1'b1);
			$display("lock done");
		end
	endtask
	initial begin
		{resetn, device_locked, debug_halt, sleep_active, wake, bus_wr, bus_rd, cmd_valid} = 0;
		{set_app_code_write_protect_bit, set_boot_section_lock_bit, bus_from_debug} = 0;
		{boot_section_end_fuse, app_code_section_end_fuse, bus_wdata, cmd_code} = 0;
		{fetch_addr, bus_addr, bus_target, halt_seen} = 0;
		{err_total, checks_done, n_wr, n_er} = 0;
		cyc(20);
		resetn = 1'b1;
		cyc(3);
		t_sections;
		t_protect;
		t_pages;
		t_clear;
		t_lock;
		test_done;
	end
	initial begin
		#800000;
		err_total = err_total + 1;
		test_done;
	end
endmodule // tb
